//--- rtl/bcr_pkg.sv
// constants, register map and carriers of the converter control bank
// assumes a serial engine on the same clock that hands over committed byte writes
//
// Notes on behaviour
// - index 0x01 is the roof register; run bit D7 is shared with the floor register.
// - run bit 0 keeps the converter shut down whatever the turn-on pin does.
// - run bit 1 lets the turn-on pin enable (high) or disable (low) the converter.
// - six-bit codes are unsigned linear: minimum voltage plus code times 12.5 mV.
// - roof code is the output target while the level choice pin is high.
// - roof register resets to run 1, free 0, code from the factory default.
// - mode register at 0x02: D7..D6 read zero, others read/write, reset zero.
// - override 00 picks the mode by the level choice pin: roof bit D1 when high, automatic when low.
// - override 10 forces PWM regardless of the level choice pin.
// - override 01 or 11 selects automatic PFM/PWM regardless of the pin.
// - pin high, no override: roof bit D1 0 is forced PWM, 1 automatic.
// - pin low, no override: always automatic; floor bit D0 only stored.
// - register 0x03 D6 set discharges the output while the converter is disabled.
// - output good flag D5 reads 1 while the output is in regulation, the converter is enabled and the ramp has settled.
// - ramp codes 000..110 double the rate from slowest up; 111 applies immediately.
// - floor code at 0x00 is the target while the level choice pin is low.
// - a written byte is committed at the strobe marking its last bit.
// - writes are refused while the turn-on pin is low; run bit 0 does not block.
package bcr_pkg;
	localparam logic [7:0] BCR_IDX_FLOOR = 8'h00;
	localparam logic [7:0] BCR_IDX_ROOF = 8'h01;
	localparam logic [7:0] BCR_IDX_MODE = 8'h02;
	localparam logic [7:0] BCR_IDX_OUT = 8'h03;
	localparam logic [7:0] BCR_RD_UNMAPPED = 8'h00;

	localparam int BCR_CODE_W = 6;
	localparam int BCR_RUN_POS = 7;
	localparam int BCR_FREE_POS = 6;
	localparam int BCR_MODE_W = 6;
	localparam int BCR_OVR_LSB = 2;
	localparam int BCR_ROOF_BEH_POS = 1;
	localparam int BCR_FLOOR_BEH_POS = 0;
	localparam int BCR_DISCH_POS = 6;
	localparam int BCR_GOOD_POS = 5;
	localparam int BCR_RAMP_LSB = 0;
	localparam int BCR_RAMP_W = 3;

	localparam logic [1:0] BCR_OVR_NONE = 2'h0;
	localparam logic [1:0] BCR_OVR_PWM = 2'h2;
	localparam logic [1:0] BCR_RSVD_RD = 2'h0;
	localparam logic [2:0] BCR_RAMP_NOW = 3'h7;

	localparam logic BCR_RUN_RST = 1'b1;
	localparam logic BCR_FREE_RST = 1'b0;
	localparam logic [5:0] BCR_MODE_RST = 6'h00;
	localparam logic [7:0] BCR_OUT_RST = 8'h47;

	// slowest ramp: one 12.5 mV step at 0.15 mV/us
	localparam int BCR_STEP_UV = 12500;
	localparam int BCR_SLOW_RATE_UV_US = 150;
	localparam int BCR_CLK_MHZ = 250;
	localparam int BCR_SLOW_CYC = BCR_STEP_UV * BCR_CLK_MHZ / BCR_SLOW_RATE_UV_US;

	typedef struct packed {
		logic stb;
		logic [7:0] idx;
		logic [7:0] data;
	} bcr_wr_t;

	typedef struct packed {
		logic conv_en;
		logic forced_pwm;
		logic discharge;
	} bcr_ctl_t;

	typedef struct packed {
		logic en_s1;
		logic en_s2;
		logic lvl_s1;
		logic lvl_s2;
		logic good_s1;
		logic good_s2;
		logic run;
		logic [6:0] floor_r;
		logic [6:0] roof_r;
		logic [5:0] mode_r;
		logic [7:0] out_r;
		logic [7:0] rdata;
		bcr_ctl_t ctl;
	} bcr_core_t;
endpackage : bcr_pkg

//--- rtl/bcr_ramp.sv
// output code stepper: walks the applied code toward the target
// assumes target and rate code come from flops on the same clock
`timescale 1ns/1ps
`default_nettype none
module bcr_ramp #(
	parameter int SLOW_CYC = bcr_pkg::BCR_SLOW_CYC,
	parameter logic [5:0] RST_CODE = 6'h00
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// target and rate
	input wire logic [5:0] target,
	input wire logic [2:0] slew,
	// applied code
	output logic [5:0] code,
	output logic settled
);
	import bcr_pkg::*;

	localparam int CW = $clog2(SLOW_CYC + 1);

	typedef struct packed {
		logic [CW-1:0] cnt;
		logic [5:0] code;
	} bcr_ramp_st_t;

	bcr_ramp_st_t st_r;
	bcr_ramp_st_t st_nxt;

	// the fastest rate still needs at least one cycle per step
	if (SLOW_CYC < 64) begin : g_bad_slow
		$error("bcr_ramp: SLOW_CYC must be at least 64");
	end

	always_comb begin
		logic [CW-1:0] lim;
		lim = CW'(SLOW_CYC >> slew);
		st_nxt = st_r;
		if (st_r.code == target) begin
			st_nxt.cnt = '0;
		end else if (slew == BCR_RAMP_NOW) begin
			st_nxt.code = target;
			st_nxt.cnt = '0;
		end else if (st_r.cnt >= lim - 1'b1) begin
			// one lsb per interval, interval halves per rate code
			st_nxt.cnt = '0;
			st_nxt.code = (st_r.code < target) ? st_r.code + 1'b1 : st_r.code - 1'b1;
		end else begin
			st_nxt.cnt = st_r.cnt + 1'b1;
		end
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r <= '{cnt: '0, code: RST_CODE};
		end else begin
			st_r <= st_nxt;
		end
	end

	assign code = st_r.code;
	assign settled = (st_r.code == target);

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_RAMP_NOW:
	assert property (slew == BCR_RAMP_NOW && code != target |=> code == $past(target))
	else $error("immediate ramp did not apply the target");

	AST_RAMP_ONE_STEP:
	assert property (slew != BCR_RAMP_NOW && $past(slew) != BCR_RAMP_NOW |->
		(code == $past(code) || code == $past(code) + 1'b1 || code == $past(code) - 1'b1))
	else $error("ramp moved more than one step");
endmodule : bcr_ramp
`default_nettype wire

//--- rtl/bcr_regs.sv
// control register bank of the step-down converter with mode and ramp logic
// assumes the serial engine strobes wr once per committed data byte, same clock
`timescale 1ns/1ps
`default_nettype none
module bcr_regs #(
	parameter logic [5:0] DEF_CODE = 6'h20,
	parameter int RAMP_SLOW_CYC = bcr_pkg::BCR_SLOW_CYC
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst,
	// register port from the serial engine
	input wire bcr_pkg::bcr_wr_t wr,
	input wire logic [7:0] rd_idx,
	output logic [7:0] rd_data,
	// device pins and analog status
	input wire logic turn_on_pin,
	input wire logic level_choice_pin,
	input wire logic out_in_reg,
	// converter controls
	output bcr_pkg::bcr_ctl_t ctl,
	output logic [5:0] vout_code
);
	import bcr_pkg::*;

	// reset image: run 1, free 0, both codes at the factory default
	localparam bcr_core_t ST_RST = '{
		run: BCR_RUN_RST,
		floor_r: {BCR_FREE_RST, DEF_CODE},
		roof_r: {BCR_FREE_RST, DEF_CODE},
		mode_r: BCR_MODE_RST,
		out_r: BCR_OUT_RST,
		default: '0
	};

	if (RAMP_SLOW_CYC < 64) begin : g_bad_ramp
		$error("bcr_regs: RAMP_SLOW_CYC must be at least 64");
	end

	bcr_core_t st_r;
	bcr_core_t st_nxt;
	logic [5:0] target;
	logic [2:0] slew;
	logic settled;

	// target follows the synchronised pin the cycle it changes
	assign target = st_r.lvl_s2 ? st_r.roof_r[BCR_CODE_W-1:0]
		: st_r.floor_r[BCR_CODE_W-1:0];
	assign slew = st_r.out_r[BCR_RAMP_LSB +: BCR_RAMP_W];

	// codes pass unsigned and unscaled; the analog side adds the offset
	bcr_ramp #(
		.SLOW_CYC(RAMP_SLOW_CYC),
		.RST_CODE(DEF_CODE)
	) u_ramp (
		.clock(clock),
		.rst(rst),
		.target(target),
		.slew(slew),
		.code(vout_code),
		.settled(settled)
	);

	always_comb begin
		logic [1:0] ovr;
		logic pwm;
		logic run_on;
		ovr = 2'h0;
		pwm = 1'b0;
		run_on = 1'b0;
		st_nxt = st_r;

		// pins come from outside the clock domain
		st_nxt.en_s1 = turn_on_pin;
		st_nxt.en_s2 = st_r.en_s1;
		st_nxt.lvl_s1 = level_choice_pin;
		st_nxt.lvl_s2 = st_r.lvl_s1;
		st_nxt.good_s1 = out_in_reg;
		st_nxt.good_s2 = st_r.good_s1;

		// grounded turn-on pin blocks updates; run bit 0 does not
		if (wr.stb && st_r.en_s2) begin
			case (wr.idx)
				BCR_IDX_FLOOR: begin
					st_nxt.run = wr.data[BCR_RUN_POS];
					st_nxt.floor_r = wr.data[BCR_FREE_POS:0];
				end
				BCR_IDX_ROOF: begin
					st_nxt.run = wr.data[BCR_RUN_POS];
					st_nxt.roof_r = wr.data[BCR_FREE_POS:0];
				end
				BCR_IDX_MODE: begin
					st_nxt.mode_r = wr.data[BCR_MODE_W-1:0];
				end
				BCR_IDX_OUT: begin
					st_nxt.out_r = wr.data;
				end
				default: begin
				end
			endcase
		end

		// enable gate: run bit masks the pin
		run_on = st_r.run && st_r.en_s2;
		st_nxt.ctl.conv_en = run_on;

		// mode selection, override first
		ovr = st_r.mode_r[BCR_OVR_LSB +: 2];
		case (ovr)
			BCR_OVR_NONE: begin
				// floor behavior bit is kept but never consulted
				pwm = st_r.lvl_s2 && !st_r.mode_r[BCR_ROOF_BEH_POS];
			end
			BCR_OVR_PWM: begin
				pwm = 1'b1;
			end
			default: begin
				pwm = 1'b0;
			end
		endcase
		st_nxt.ctl.forced_pwm = pwm;

		// discharge only while the converter is off
		st_nxt.ctl.discharge = st_r.out_r[BCR_DISCH_POS] && !run_on;

		// status bit is owned by hardware, so a write to it never sticks
		st_nxt.out_r[BCR_GOOD_POS] = st_r.good_s2 && st_r.ctl.conv_en && settled;

		// read port, one cycle behind the index
		case (rd_idx)
			BCR_IDX_FLOOR: st_nxt.rdata = {st_r.run, st_r.floor_r};
			BCR_IDX_ROOF: st_nxt.rdata = {st_r.run, st_r.roof_r};
			BCR_IDX_MODE: st_nxt.rdata = {BCR_RSVD_RD, st_r.mode_r};
			BCR_IDX_OUT: st_nxt.rdata = st_r.out_r;
			default: st_nxt.rdata = BCR_RD_UNMAPPED;
		endcase
	end

	always_ff @(posedge clock or posedge rst) begin
		if (rst) begin
			st_r <= ST_RST;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign rd_data = st_r.rdata;
	assign ctl = st_r.ctl;

	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);

	AST_RUN_OFF_HOLDS:
	assert property (!st_r.run |=> !ctl.conv_en)
	else $error("converter enabled with run bit clear");

	AST_RUN_FOLLOWS_PIN:
	assert property (st_r.run && st_r.en_s2 |=> ctl.conv_en)
	else $error("converter not enabled with run bit and pin high");

	AST_PIN_LOW_OFF:
	assert property (!st_r.en_s2 |=> !ctl.conv_en)
	else $error("converter enabled with turn-on pin low");

	AST_RUN_MIRROR:
	assert property (wr.stb && st_r.en_s2 && wr.idx == BCR_IDX_ROOF
		|=> st_r.run == $past(wr.data[BCR_RUN_POS]))
	else $error("roof write did not update the shared run bit");

	AST_MIRROR_READ:
	assert property (rd_idx == BCR_IDX_FLOOR ##1 rd_idx == BCR_IDX_ROOF && $stable(st_r.run)
		|=> rd_data[BCR_RUN_POS] == $past(rd_data[BCR_RUN_POS]))
	else $error("run bit differs between floor and roof reads");

	AST_HW_OFF_REFUSED:
	assert property (wr.stb && !st_r.en_s2 |=> $stable(st_r.run) && $stable(st_r.floor_r)
		&& $stable(st_r.roof_r) && $stable(st_r.mode_r))
	else $error("register updated while turn-on pin low");

	AST_MODE_RSVD:
	assert property (rd_idx == BCR_IDX_MODE |=> rd_data[BCR_RUN_POS:BCR_MODE_W] == BCR_RSVD_RD)
	else $error("reserved mode bits read nonzero");

	AST_OVR_PWM:
	assert property (st_r.mode_r[BCR_OVR_LSB +: 2] == BCR_OVR_PWM |=> ctl.forced_pwm)
	else $error("override 10 did not force pwm");

	AST_OVR_AUTO:
	assert property (st_r.mode_r[BCR_OVR_LSB] |=> !ctl.forced_pwm)
	else $error("override 01/11 did not select automatic mode");

	AST_ROOF_MODE:
	assert property (st_r.mode_r[BCR_OVR_LSB +: 2] == BCR_OVR_NONE && st_r.lvl_s2
		|=> ctl.forced_pwm != $past(st_r.mode_r[BCR_ROOF_BEH_POS]))
	else $error("roof behavior bit not honoured");

	AST_FLOOR_AUTO:
	assert property (st_r.mode_r[BCR_OVR_LSB +: 2] == BCR_OVR_NONE && !st_r.lvl_s2
		|=> !ctl.forced_pwm)
	else $error("floor level not in automatic mode");

	AST_DISCHARGE:
	assert property (st_r.out_r[BCR_DISCH_POS] && !st_r.run |=> ctl.discharge && !ctl.conv_en)
	else $error("output not discharged while disabled");

	AST_NO_DISCHARGE_ON:
	assert property (ctl.conv_en |-> !ctl.discharge)
	else $error("discharge active while converter enabled");

	AST_GOOD_LOW_OFF:
	assert property (!ctl.conv_en |=> !st_r.out_r[BCR_GOOD_POS])
	else $error("output good reported while converter off");

	AST_LEVEL_SWITCH:
	assert property ($rose(level_choice_pin) ##1 level_choice_pin ##1 level_choice_pin
		|-> target == st_r.roof_r[BCR_CODE_W-1:0])
	else $error("target did not follow level choice pin within two cycles");

	AST_LEVEL_FALL:
	assert property ($fell(level_choice_pin) ##1 !level_choice_pin ##1 !level_choice_pin
		|-> target == st_r.floor_r[BCR_CODE_W-1:0])
	else $error("target did not return to the floor code within two cycles");

	// accepted writes land in the addressed register, whole except the good flag D5 at 0x03
	AST_FLOOR_WRITE:
	assert property (wr.stb && st_r.en_s2 && wr.idx == BCR_IDX_FLOOR
		|=> st_r.floor_r == $past(wr.data[BCR_FREE_POS:0])
		&& st_r.run == $past(wr.data[BCR_RUN_POS]))
	else $error("floor write did not land");

	AST_ROOF_WRITE:
	assert property (wr.stb && st_r.en_s2 && wr.idx == BCR_IDX_ROOF
		|=> st_r.roof_r == $past(wr.data[BCR_FREE_POS:0]))
	else $error("roof write did not land");

	AST_SOFT_OFF_WRITE:
	assert property (wr.stb && st_r.en_s2 && !st_r.run && wr.idx == BCR_IDX_ROOF
		|=> st_r.roof_r == $past(wr.data[BCR_FREE_POS:0]))
	else $error("write refused while only the run bit was clear");

	AST_MODE_WRITE:
	assert property (wr.stb && st_r.en_s2 && wr.idx == BCR_IDX_MODE
		|=> st_r.mode_r == $past(wr.data[BCR_MODE_W-1:0]))
	else $error("mode write did not land");

	AST_OUT_WRITE:
	assert property (wr.stb && st_r.en_s2 && wr.idx == BCR_IDX_OUT
		|=> st_r.out_r[BCR_RUN_POS:BCR_DISCH_POS] == $past(wr.data[BCR_RUN_POS:BCR_DISCH_POS])
		&& st_r.out_r[BCR_GOOD_POS-1:0] == $past(wr.data[BCR_GOOD_POS-1:0]))
	else $error("output control write did not land");

	// nothing but a committed byte may move the stored registers
	AST_NO_STROBE_HOLDS:
	assert property (!wr.stb |=> $stable(st_r.run) && $stable(st_r.floor_r)
		&& $stable(st_r.roof_r) && $stable(st_r.mode_r))
	else $error("register changed without a write strobe");

	// the immediate rate shows which code the level pin has chosen
	AST_FLOOR_NOW:
	assert property (!st_r.lvl_s2 && slew == BCR_RAMP_NOW
		|=> vout_code == $past(st_r.floor_r[BCR_CODE_W-1:0]))
	else $error("floor code not applied at floor level");

	AST_ROOF_NOW:
	assert property (st_r.lvl_s2 && slew == BCR_RAMP_NOW
		|=> vout_code == $past(st_r.roof_r[BCR_CODE_W-1:0]))
	else $error("roof code not applied at roof level");

	// status and discharge
	AST_GOOD_SET:
	assert property (st_r.good_s2 && st_r.ctl.conv_en && settled
		|=> st_r.out_r[BCR_GOOD_POS])
	else $error("output good not reported while in regulation");

	AST_GOOD_LOST:
	assert property (!st_r.good_s2
		|=> !st_r.out_r[BCR_GOOD_POS])
	else $error("output good reported while out of regulation");

	AST_DISCH_BIT_OFF:
	assert property (!st_r.out_r[BCR_DISCH_POS]
		|=> !ctl.discharge)
	else $error("output discharged with the discharge bit clear");

	// read port mapping, one cycle behind the index
	AST_READ_FLOOR:
	assert property (rd_idx == BCR_IDX_FLOOR
		|=> rd_data == $past({st_r.run, st_r.floor_r}))
	else $error("floor register read wrong");

	AST_READ_ROOF:
	assert property (rd_idx == BCR_IDX_ROOF
		|=> rd_data == $past({st_r.run, st_r.roof_r}))
	else $error("roof register read wrong");

	AST_READ_MODE:
	assert property (rd_idx == BCR_IDX_MODE
		|=> rd_data[BCR_MODE_W-1:0] == $past(st_r.mode_r))
	else $error("mode register read wrong");

	AST_READ_OUT:
	assert property (rd_idx == BCR_IDX_OUT
		|=> rd_data == $past(st_r.out_r))
	else $error("output control register read wrong");
endmodule : bcr_regs
`default_nettype wire

//--- sim/bcr_host.sv
// host-side model of the serial engine: committed byte writes and register reads
// assumes the bank samples its port on the rising clock edge
`timescale 1ns/1ps
`default_nettype none
module bcr_host (
	// clock
	input wire logic clock,
	// register port
	output bcr_pkg::bcr_wr_t wr,
	output logic [7:0] rd_idx,
	input wire logic [7:0] rd_data
);
	import bcr_pkg::*;
	initial begin
		wr = '0;
		rd_idx = 8'h00;
	end
	// one byte per strobe; strobe is held for exactly one edge
	task automatic put(input logic [7:0] idx, input logic [7:0] data);
		@(posedge clock);
		wr <= '{stb: 1'b1, idx: idx, data: data};
		@(posedge clock);
		wr.stb <= 1'b0;
	endtask : put
	// read data is registered, so it lands one edge after the index is taken
	task automatic get(input logic [7:0] idx, output logic [7:0] data);
		@(posedge clock);
		rd_idx <= idx;
		repeat (2) @(posedge clock);
		#1 data = rd_data;
	endtask : get
endmodule : bcr_host
`default_nettype wire

//--- sim/tb_top.sv
// self-checking bench of the converter control bank
// assumes bcr_regs with a shortened ramp interval and the host model
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import bcr_pkg::*;
	localparam logic [5:0] DEF = 6'h20;
	localparam int SLOW = 64;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic turn_on_pin = 1'b0;
	logic level_choice_pin = 1'b0;
	logic out_in_reg = 1'b0;
	bcr_wr_t wr;
	logic [7:0] rd_idx;
	logic [7:0] rd_data;
	logic [7:0] v;
	bcr_ctl_t ctl;
	logic [5:0] vout_code;
	int num_errors = 0;
	int total_checks = 0;
	int cycles = 0;
	always #2 clock = ~clock;
	bcr_host host (.clock(clock), .wr(wr), .rd_idx(rd_idx), .rd_data(rd_data));
	bcr_regs #(.DEF_CODE(DEF), .RAMP_SLOW_CYC(SLOW)) uut (
		.clock(clock), .rst(rst), .wr(wr), .rd_idx(rd_idx), .rd_data(rd_data),
		.turn_on_pin(turn_on_pin), .level_choice_pin(level_choice_pin),
		.out_in_reg(out_in_reg), .ctl(ctl), .vout_code(vout_code));
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, num_errors);
		if (num_errors == 0 && total_checks > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : give_verdict
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		total_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("unexpected at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
		host.get(idx, v);
		chk(v, exp);
	endtask : rd
	// pins pass a two-flop synchroniser, so give them a few edges to land
	task automatic pin(input logic on, input logic lvl);
		@(posedge clock);
		turn_on_pin <= on;
		level_choice_pin <= lvl;
		repeat (5) @(posedge clock);
		#1;
	endtask : pin
	task automatic t_reset();
		rd(8'h01, {2'b10, DEF});
		rd(8'h00, {2'b10, DEF});
		rd(8'h02, 8'h00);
		rd(8'h03, 8'h47);
		rd(8'h05, 8'h00);
		chk(vout_code, DEF);
		chk(ctl.conv_en, 1'b0);
		host.put(8'h02, 8'h0f);
		rd(8'h02, 8'h00);
	endtask : t_reset
	task automatic t_run();
		pin(1'b1, 1'b0);
		chk(ctl.conv_en, 1'b1);
		chk(ctl.discharge, 1'b0);
		host.put(8'h00, 8'h05);
		rd(8'h01, {2'b00, DEF});
		chk(ctl.conv_en, 1'b0);
		chk(ctl.discharge, 1'b1);
		host.put(8'h01, 8'h8a);
		rd(8'h00, 8'h85);
		chk(ctl.conv_en, 1'b1);
		chk(vout_code, 6'h05);
		pin(1'b1, 1'b1);
		chk(vout_code, 6'h0a);
		pin(1'b0, 1'b0);
		chk(ctl.conv_en, 1'b0);
		host.put(8'h01, 8'h81);
		rd(8'h01, 8'h8a);
		pin(1'b1, 1'b0);
	endtask : t_run
	task automatic t_mode();
		logic e;
		host.put(8'h02, 8'hff);
		rd(8'h02, 8'h3f);
		for (int k = 0; k < 16; k++) begin
			host.put(8'h02, {4'h0, k[3:2], k[1], k[1]});
			pin(1'b1, k[0]);
			e = (k[3:2] == 2'h2) || (k[3:2] == 2'h0 && k[0] && !k[1]);
			chk(ctl.forced_pwm, e);
		end
		pin(1'b1, 1'b0);
	endtask : t_mode
	task automatic t_ramp();
		host.put(8'h03, 8'h00);
		host.put(8'h00, 8'h87);
		repeat (20) @(posedge clock);
		#1;
		chk(vout_code == 6'h07, 1'b0);
		repeat (150) @(posedge clock);
		#1;
		chk(vout_code, 6'h07);
		host.put(8'h03, 8'h06);
		host.put(8'h00, 8'h80);
		#1;
		chk(vout_code == 6'h00, 1'b0);
		repeat (20) @(posedge clock);
		#1;
		chk(vout_code, 6'h00);
		// rate code 5 gives two cycles per step with the short interval
		host.put(8'h03, 8'h05);
		host.put(8'h00, 8'h84);
		repeat (5) @(posedge clock);
		#1;
		chk(vout_code, 6'h02);
		repeat (5) @(posedge clock);
		#1;
		chk(vout_code, 6'h04);
		host.put(8'h03, 8'h07);
		host.put(8'h00, 8'h9f);
		repeat (3) @(posedge clock);
		#1;
		chk(vout_code, 6'h1f);
	endtask : t_ramp
	task automatic t_good();
		@(posedge clock);
		out_in_reg <= 1'b1;
		repeat (5) @(posedge clock);
		rd(8'h03, 8'h27);
		// converter off with the discharge bit clear: no discharge, no good flag
		pin(1'b0, 1'b0);
		chk(ctl.discharge, 1'b0);
		rd(8'h03, 8'h07);
		pin(1'b1, 1'b0);
		@(posedge clock);
		out_in_reg <= 1'b0;
		repeat (5) @(posedge clock);
		rd(8'h03, 8'h07);
	endtask : t_good
	// a second reset in mid-run must bring back the whole reset image
	task automatic t_rerst();
		pin(1'b0, 1'b0);
		@(posedge clock);
		rst <= 1'b1;
		repeat (3) @(posedge clock);
		rst <= 1'b0;
		t_reset();
	endtask : t_rerst
	always @(posedge clock) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			num_errors++;
			give_verdict();
		end
	end
	initial begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset();
		t_run();
		t_mode();
		t_ramp();
		t_good();
		t_rerst();
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
